// ---- hw/global_sector_protect_control.sv ----
// Global sector protect and unprotect control with an AXI4-Lite view.
//
// Operation
// - Only a status write runs global operations and updates the lock.
// - A permitted write with bits 5:2 all one protects every sector.
// - A permitted write with bits 5:2 all zero unprotects every sector.
// - Any other pattern in bits 5:2 leaves every sector bit unchanged.
// - With lock zero globals run whatever the pin, and lock takes bit 7.
// - With the pin low and lock one, global requests change no sector.
// - Hard-locked, the lock stays one; only a high pin lets it clear.
// - Sector commands still work on top of any global state, with the latch set and lock zero.
// - Without the write enable latch set, no status write executes.
// - A set sector bit blocks program and erase; all are set at reset.
// - Pin high and lock one: no global runs, but lock takes bit 7.
// - Bits 5:2 are decoded, never stored; only bit 7 is kept as lock.
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module global_sector_protect_control (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cs_n,
  input  wire logic        wp_n,
  input  wire logic        write_enable_latch,
  input  wire logic        wrsr_done,
  input  wire logic [7:0]  wrsr_data,
  input  wire logic        sec_cmd_done,
  input  wire logic        sec_cmd_protect,
  input  wire logic [5:0]  sec_cmd_sector,
  input  wire logic [5:0]  pe_sector,
  output logic             pe_blocked,
  output logic             latch_clear,
  output logic             protection_regs_locked,
  output logic [63:0]      sector_protect
);

  typedef struct packed {
    logic [63:0] prot;
    logic        lock;
    logic        wrsr_pend;
    logic [7:0]  wrsr_byte;
    logic        sec_pend;
    logic        sec_set;
    logic [5:0]  sec_idx;
    logic        latch_clr;
    logic        aw_got;
    logic [3:0]  aw_addr;
    logic        w_got;
    logic [7:0]  w_byte;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic       spi_apply;
  logic       sec_apply;
  logic       wr_done;
  logic       sw_apply;
  logic       do_wrsr;
  logic [7:0] wr_byte;

  ////////////////////////////////////////////////////////////////////////////

  function automatic gsp_pkg::gop_t global_op(input logic [7:0] d);
    logic [3:0] f;
    f = d[gsp_pkg::SR_GLOB_MSB:gsp_pkg::SR_GLOB_LSB];
    if (f == gsp_pkg::GLOB_ALL_ONE) begin
      return gsp_pkg::GOP_SET;
    end else if (f == gsp_pkg::GLOB_ALL_ZERO) begin
      return gsp_pkg::GOP_CLEAR;
    end
    return gsp_pkg::GOP_NONE;
  endfunction

  function automatic logic reg_mapped(input logic [3:0] a, input logic wr);
    case (a)
      gsp_pkg::STATUS_OFS,
      gsp_pkg::PROT_LO_OFS,
      gsp_pkg::PROT_HI_OFS: return !wr;
      gsp_pkg::SW_WRSR_OFS: return wr;
      default:              return 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  assign spi_apply = st_r.wrsr_pend && cs_n;
  assign sec_apply = st_r.sec_pend && cs_n;
  assign wr_done   = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  // A software write waits one cycle if a serial status write applies now.
  assign sw_apply  = wr_done && !spi_apply && st_r.w_lane0 &&
                     (st_r.aw_addr == gsp_pkg::SW_WRSR_OFS);
  assign do_wrsr   = spi_apply || sw_apply;
  assign wr_byte   = spi_apply ? st_r.wrsr_byte : st_r.w_byte;

  assign s_axi_awready          = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready           = !st_r.w_got && !st_r.bvalid;
  assign s_axi_bvalid           = st_r.bvalid;
  assign s_axi_bresp            = st_r.bresp;
  assign s_axi_arready          = !st_r.rvalid;
  assign s_axi_rvalid           = st_r.rvalid;
  assign s_axi_rdata            = st_r.rdata;
  assign s_axi_rresp            = st_r.rresp;
  assign latch_clear            = st_r.latch_clr;
  assign protection_regs_locked = st_r.lock;
  assign sector_protect         = st_r.prot;
  assign pe_blocked             = st_r.prot[pe_sector];

  always_comb begin
    st_nxt           = st_r;
    st_nxt.latch_clr = 1'b0;
    // Serial capture: a new frame replaces a pending one of its own kind not yet applied.
    if (!cs_n && wrsr_done) begin
      st_nxt.wrsr_pend = 1'b1;
      st_nxt.wrsr_byte = wrsr_data;
    end
    if (!cs_n && sec_cmd_done) begin
      st_nxt.sec_pend = 1'b1;
      st_nxt.sec_set  = sec_cmd_protect;
      st_nxt.sec_idx  = sec_cmd_sector;
    end
    if (spi_apply) begin
      st_nxt.wrsr_pend = 1'b0;
    end
    if (do_wrsr) begin
      st_nxt.latch_clr = 1'b1;
      if (write_enable_latch) begin
        if (!st_r.lock) begin
          case (global_op(wr_byte))
            gsp_pkg::GOP_SET:   st_nxt.prot = '1;
            gsp_pkg::GOP_CLEAR: st_nxt.prot = '0;
            default:            st_nxt.prot = st_r.prot;
          endcase
          st_nxt.lock = wr_byte[gsp_pkg::SR_LOCK_BIT];
        end else if (wp_n) begin
          st_nxt.lock = wr_byte[gsp_pkg::SR_LOCK_BIT];
        end
        // hard lock ignores; lock held by falling through.
      end
    end
    if (sec_apply) begin
      st_nxt.sec_pend = 1'b0;
      st_nxt.latch_clr = 1'b1;
      if (write_enable_latch && !st_r.lock) begin
        st_nxt.prot[st_r.sec_idx] = st_r.sec_set;
      end
    end
    // AXI write channel.
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got   = 1'b1;
      st_nxt.w_byte  = s_axi_wdata[7:0];
      st_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (wr_done && (sw_apply || st_r.aw_addr != gsp_pkg::SW_WRSR_OFS ||
                    !st_r.w_lane0)) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = reg_mapped(st_r.aw_addr, 1'b1) ?
                      gsp_pkg::RESP_OKAY : gsp_pkg::RESP_DECERR;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // AXI read channel.
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = reg_mapped(s_axi_araddr, 1'b0) ?
                      gsp_pkg::RESP_OKAY : gsp_pkg::RESP_DECERR;
      st_nxt.rdata  = '0;
      case (s_axi_araddr)
        gsp_pkg::STATUS_OFS: begin
          st_nxt.rdata[gsp_pkg::ST_LOCK_BIT] = st_r.lock;
          st_nxt.rdata[gsp_pkg::ST_WP_N_BIT] = wp_n;
          st_nxt.rdata[gsp_pkg::ST_LATCH_BIT] = write_enable_latch;
          st_nxt.rdata[gsp_pkg::ST_ALL_BIT]  = &st_r.prot;
          st_nxt.rdata[gsp_pkg::ST_NONE_BIT] = ~|st_r.prot;
          st_nxt.rdata[gsp_pkg::ST_PEND_BIT] = st_r.wrsr_pend;
        end
        gsp_pkg::PROT_LO_OFS: st_nxt.rdata = st_r.prot[31:0];
        gsp_pkg::PROT_HI_OFS: st_nxt.rdata = st_r.prot[63:32];
        default:              st_nxt.rdata = '0;
      endcase
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r      <= '0;
      st_r.prot <= gsp_pkg::PROT_RST;
      st_r.lock <= gsp_pkg::LOCK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic permit;
  assign permit = do_wrsr && write_enable_latch && !st_r.lock;

  no_latch_a: assert property (
    do_wrsr && !write_enable_latch && !sec_apply
    |=> $stable(st_r.prot) && $stable(st_r.lock))
    else $error("status write ran without write enable");
  hard_lock_a: assert property (
    do_wrsr && st_r.lock && !wp_n && !sec_apply |=> $stable(st_r.prot))
    else $error("hard lock let sectors change");
  lock_held_a: assert property (
    st_r.lock && !wp_n |=> st_r.lock)
    else $error("lock dropped while pin low");
  glob_set_a: assert property (
    permit && !sec_apply && wr_byte[5:2] == 4'hf |=> &st_r.prot)
    else $error("global protect missed");
  glob_clr_a: assert property (
    permit && !sec_apply && wr_byte[5:2] == 4'h0 |=> st_r.prot == '0)
    else $error("global unprotect missed");
  glob_mix_a: assert property (
    permit && !sec_apply && wr_byte[5:2] != 4'hf && wr_byte[5:2] != 4'h0
    |=> $stable(st_r.prot))
    else $error("mixed pattern changed sectors");
  lock_take_a: assert property (
    permit |=> st_r.lock == $past(wr_byte[7]))
    else $error("lock did not take bit 7");
  soft_lock_a: assert property (
    do_wrsr && write_enable_latch && st_r.lock && wp_n && !sec_apply
    |=> $stable(st_r.prot) && st_r.lock == $past(wr_byte[7]))
    else $error("soft lock handling wrong");
  frame_a: assert property (
    !cs_n && !sw_apply |=> $stable(st_r.prot) && $stable(st_r.lock))
    else $error("update before chip select high");
  sector_a: assert property (
    sec_apply && !do_wrsr && write_enable_latch && !st_r.lock
    |=> st_r.prot[$past(st_r.sec_idx)] == $past(st_r.sec_set))
    else $error("single sector update lost");
  // Reset itself is what this watches, so the default disable is overridden.
  reset_val_a: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> &st_r.prot && st_r.lock == gsp_pkg::LOCK_RST)
    else $error("sectors not protected after reset");

  cov_gunprot_c: cover property (permit && wr_byte[5:2] == 4'h0);
  cov_hard_c:    cover property (do_wrsr && st_r.lock && !wp_n);
  cov_soft_c:    cover property (do_wrsr && st_r.lock && wp_n && !wr_byte[7]);
  cov_sector_c:  cover property (sec_apply && write_enable_latch);

endmodule

// ---- shared/gsp_pkg.sv ----
// Constants shared by the global sector protection control logic.
package gsp_pkg;
  localparam int unsigned SECTORS       = 64;
  localparam int unsigned SECTOR_W      = 6;
  // Register byte addresses on the AXI4-Lite slave.
  localparam logic [3:0]  STATUS_OFS    = 4'h0;
  localparam logic [3:0]  PROT_LO_OFS   = 4'h4;
  localparam logic [3:0]  PROT_HI_OFS   = 4'h8;
  localparam logic [3:0]  SW_WRSR_OFS   = 4'hc;
  // Status register data fields.
  localparam int unsigned SR_LOCK_BIT   = 7;
  localparam int unsigned SR_GLOB_MSB   = 5;
  localparam int unsigned SR_GLOB_LSB   = 2;
  localparam logic [3:0]  GLOB_ALL_ONE  = 4'hf;
  localparam logic [3:0]  GLOB_ALL_ZERO = 4'h0;
  // Fields of the STATUS read word.
  localparam int unsigned ST_LOCK_BIT   = 0;
  localparam int unsigned ST_WP_N_BIT   = 1;
  localparam int unsigned ST_LATCH_BIT  = 2;
  localparam int unsigned ST_ALL_BIT    = 3;
  localparam int unsigned ST_NONE_BIT   = 4;
  localparam int unsigned ST_PEND_BIT   = 5;
  // Reset values.
  localparam logic [63:0] PROT_RST      = 64'hffffffffffffffff;
  localparam logic        LOCK_RST      = 1'b0;
  // AXI responses.
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;
  // Global operation codes.
  typedef enum logic [1:0] {
    GOP_NONE  = 2'b00,
    GOP_SET   = 2'b01,
    GOP_CLEAR = 2'b10
  } gop_t;
endpackage

// ---- test/spi_host_model.sv ----
// Serial host model that issues status and single-sector write frames.
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic       aclk,
  output logic            cs_n,
  output logic            wrsr_done,
  output logic [7:0]      wrsr_data,
  output logic            sec_cmd_done,
  output logic            sec_cmd_protect,
  output logic [5:0]      sec_cmd_sector
);
  initial begin
    cs_n = 1'b1;
    wrsr_done = 1'b0;
    wrsr_data = 8'h5a;
    sec_cmd_done = 1'b0;
    sec_cmd_protect = 1'b0;
    sec_cmd_sector = 6'h2a;
  end

  // Kind 0 is a status write, 1 a sector command, 2 a frame cut short.
  // whole frame, then release
  task automatic frame(input logic [1:0] kind, input logic [7:0] b);
    @(posedge aclk);
    cs_n <= 1'b0;
    @(posedge aclk);
    wrsr_done <= (kind == 2'h0);
    sec_cmd_done <= (kind == 2'h1);
    wrsr_data <= b;
    sec_cmd_protect <= b[6];
    sec_cmd_sector <= b[5:0];
    @(posedge aclk);
    wrsr_done <= 1'b0;
    sec_cmd_done <= 1'b0;
    // Released data lines flip so that a stale value is never reused.
    wrsr_data <= ~b;
    sec_cmd_sector <= ~b[5:0];
    sec_cmd_protect <= ~b[6];
    @(posedge aclk);
    cs_n <= 1'b1;
    @(posedge aclk);
  endtask
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the global sector protection control.
`timescale 1ns/1ps
module tb;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, rd;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_bvalid;
  logic        s_axi_awready, s_axi_wready, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        cs_n, wrsr_done, sec_cmd_done, sec_cmd_protect;
  logic        wp_n = 1'b1, write_enable_latch = 1'b0;
  logic        pe_blocked, latch_clear, protection_regs_locked;
  logic [7:0]  wrsr_data;
  logic [5:0]  es;
  logic [5:0]  sec_cmd_sector, pe_sector = 6'h0;
  logic [63:0] sector_protect, m_prot = 64'hffffffffffffffff;
  logic [3:0]  pats [4] = '{4'h0, 4'hf, 4'h1, 4'he};
  int          m_lock = 0, error_cnt = 0, n_compared = 0, i, n;
  int          seed = 32'h1e97;

  always #50 aclk = ~aclk;

  global_sector_protect_control global_sector_protect_control_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cs_n, .wp_n, .write_enable_latch, .wrsr_done,
    .wrsr_data, .sec_cmd_done, .sec_cmd_protect, .sec_cmd_sector,
    .pe_sector, .pe_blocked, .latch_clear, .protection_regs_locked,
    .sector_protect
  );
  spi_host_model spi_host_model_i (
    .aclk, .cs_n, .wrsr_done, .wrsr_data, .sec_cmd_done, .sec_cmd_protect,
    .sec_cmd_sector
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [63:0] e, g);
    n_compared++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      error_cnt++;
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic tmo(input logic seen);
    if (seen !== 1'b1) begin
      $display("BAD handshake exp %h got %h", 1'b1, 1'b0);
      error_cnt++;
      tally_and_finish();
    end
  endtask

  // The model decides with the lock held before the write.
  task automatic m_wrsr(input logic [7:0] b);
    if (write_enable_latch && !(m_lock == 1 && !wp_n)) begin
      if (m_lock == 0 && b[5:2] == 4'hf) m_prot = '1;
      if (m_lock == 0 && b[5:2] == 4'h0) m_prot = '0;
      m_lock = b[7];
    end
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    tmo(s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [3:0] a);
    n = 0;
    // A spare edge keeps rready from being driven twice in one time step.
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    tmo(s_axi_rvalid);
    r = s_axi_rresp;
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask

  task automatic ckst;
    #1;
    chk("sector_protect", m_prot, sector_protect);
    chk("lock", m_lock, protection_regs_locked);
    chk("pe_blocked", m_prot[pe_sector], pe_blocked);
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    ckst();
    for (i = 0; i < 80; i++) begin
      d = $random(seed);
      d[5:2] = pats[d[9:8]];
      wp_n <= d[10];
      write_enable_latch <= d[11] | d[12];
      pe_sector <= d[20:15];
      case (d[14:13])
        2'h0: spi_host_model_i.frame(2'h0, d[7:0]);
        2'h1: axw(gsp_pkg::SW_WRSR_OFS, d);
        2'h2: spi_host_model_i.frame(2'h1, d[7:0]);
        default: spi_host_model_i.frame(2'h2, d[7:0]);
      endcase
      if (d[14:13] == 2'h1) chk("bresp", gsp_pkg::RESP_OKAY, r);
      if (d[14:13] < 2'h2) m_wrsr(d[7:0]);
      if (d[14:13] == 2'h2 && write_enable_latch && m_lock == 0) begin
        m_prot[d[5:0]] = d[6];
      end
      ckst();
      chk("latch_clear", !d[13], latch_clear);
      axr(gsp_pkg::PROT_LO_OFS);
      chk("prot_lo", m_prot[31:0], rd);
      axr(gsp_pkg::PROT_HI_OFS);
      chk("prot_hi", m_prot[63:32], rd);
      axr(gsp_pkg::STATUS_OFS);
      es = {1'b0, ~|m_prot, &m_prot, write_enable_latch, wp_n, m_lock[0]};
      chk("status", es, rd[5:0]);
      chk("rresp", gsp_pkg::RESP_OKAY, r);
    end
    axw(gsp_pkg::STATUS_OFS, 32'h0);
    chk("bresp_ro", gsp_pkg::RESP_DECERR, r);
    axr(gsp_pkg::SW_WRSR_OFS);
    chk("rresp_wo", gsp_pkg::RESP_DECERR, r);
    ckst();
    tally_and_finish();
  end
endmodule
